// ==== src/subscriber_line_link_pkg.sv ====
// Purpose: Constants for the module-side slave of the subscriber line link.
// Assumes: 40 MHz block clock, 512 kHz link clock from the line interface board.
// Notes: Rules of the block follow, one to a line.
// Function
// - Board is timing master; module follows strobe.
// - Asserted interface reset blocks all board calls.
// - Frame holds voice, data, control, signaling bytes.
// - Voice slot carries one 8-bit sample per frame.
// - Data byte slot is unused both ways.
// - Six control bytes; framing bit 0 then 1.
// - Control bit six is active-low write enable.
// - Hook bit 0 off-hook, 1 on-hook.
// - Other outbound signaling bits stay unused.
// - Returned signaling reports line current and pins.
// - First general pin is ring; current bit.
// - Ignore other general pins and undefined bits.
// - Transmit valid only while strobe asserted.
// - Sample strap: one wire or two wires.
// - Board stays reset until run line reasserted.

package subscriber_line_link_pkg;
  // ==========================================================
  // Timing.
  localparam int CLOCK_KHZ = 40000;
  localparam int LINK_CLOCK_KHZ = 512;
  localparam int LINK_HALF_CYCLES = CLOCK_KHZ / (2 * LINK_CLOCK_KHZ);
  // ==========================================================
  // Frame layout, most significant bit sent first.
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] FRAME_BITS_W = 6'h20;
  localparam int VOICE_LSB = 24;
  localparam int DATA_LSB = 16;
  localparam int CTRL_LSB = 8;
  localparam int SIG_LSB = 0;
  localparam logic [7:0] DATA_IDLE = 8'h00;
  // ==========================================================
  // Control byte fields.
  localparam int CTRL_FRAME_POS = 7;
  localparam int CTRL_WE_B_POS = 6;
  localparam int PROG_BYTES = 6;
  localparam logic [2:0] PROG_LAST = 3'h5;
  localparam logic [7:0] CTRL_IDLE = 8'hC0;
  // ==========================================================
  // Signaling byte fields.
  localparam int HOOK_POS = 0;
  localparam int RING_POS = 0;
  localparam int CURRENT_POS = 4;
  localparam logic [7:0] SIG_IDLE = 8'h00;
  // ==========================================================
  // Synchroniser lanes.
  localparam int SY_CLK = 0;
  localparam int SY_DIR = 1;
  localparam int SY_RX = 2;
  localparam int SY_TXI = 3;
  localparam int SY_STRAP = 4;
  localparam int SY_N = 5;
endpackage : subscriber_line_link_pkg

// ==== src/subscriber_line_link_slave.sv ====
// Purpose: Module-side timing slave of the subscriber line link.
// Assumes: Link clock, strobe and data pins are asynchronous to clock_in.
// Notes: Link edges are found by oversampling; no second clock domain.
`timescale 1ns/1ps
`default_nettype none
module subscriber_line_link_slave (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Link pins from the line interface board.
  input wire logic link_clock_in,
  input wire logic link_direction_strobe_in,
  input wire logic rx_data_in,
  input wire logic one_wire_b_in,
  // Transmit wire, two-way in one-wire mode.
  input wire logic tx_data_in,
  output logic tx_data_out,
  output logic tx_data_oe_out,
  // Interface reset line, high lets the board run.
  output logic interface_reset_line_out,
  // User side controls.
  input wire logic run_enable_in,
  input wire logic hook_off_in,
  input wire logic [7:0] tx_voice_in,
  input wire logic prog_start_in,
  input wire logic prog_write_in,
  input wire logic [35:0] prog_bits_in,
  // User side status.
  output logic prog_busy_out,
  output logic voice_taken_out,
  output logic [7:0] voice_out,
  output logic voice_valid_out,
  output logic ring_detect_out,
  output logic line_current_out,
  output logic [7:0] id_code_out,
  output logic id_valid_out,
  output logic one_wire_out
);
  import subscriber_line_link_pkg::*;

  // ==========================================================
  // Pin synchronisers and edge detection.
  logic [SY_N-1:0] sync1;
  logic [SY_N-1:0] sync2;
  logic lclk_d;
  logic dir_d;
  logic lclk_fall;
  logic dir_rise;
  logic dir_fall;

  // Two flops per pin before any logic looks at it.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {one_wire_b_in, tx_data_in, rx_data_in, link_direction_strobe_in,
                link_clock_in};
      sync2 <= sync1;
    end
  end

  // Previous synchronised levels for edge finding.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lclk_d <= 1'b0;
      dir_d <= 1'b0;
    end else begin
      lclk_d <= sync2[SY_CLK];
      dir_d <= sync2[SY_DIR];
    end
  end

  // Edges of the master's clock and strobe drive all timing.
  assign lclk_fall = lclk_d & ~sync2[SY_CLK];
  assign dir_rise = ~dir_d & sync2[SY_DIR];
  assign dir_fall = dir_d & ~sync2[SY_DIR];

  // ==========================================================
  // Interface reset line and wire-mode strap.
  logic go;
  logic one_wire;

  // Low during module reset and until software asks to run.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      go <= 1'b0;
    end else begin
      go <= run_enable_in;
    end
  end

  // The strap is only taken while the board is held in reset.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      one_wire <= 1'b0;
    end else if (!go) begin
      one_wire <= ~sync2[SY_STRAP];
    end
  end

  // ==========================================================
  // Programming sequence store and sequencer.
  logic [5:0] prog_mem [0:PROG_BYTES-1];
  logic [2:0] prog_index;
  logic prog_busy;
  logic prog_we;
  logic tx_load;

  assign tx_load = dir_rise & go;

  // Payload bytes are captured when a sequence starts.
  generate
    for (genvar i = 0; i < PROG_BYTES; i++) begin : g_prog
      always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          prog_mem[i] <= 6'h00;
        end else if (prog_start_in) begin
          prog_mem[i] <= prog_bits_in[(PROG_BYTES-1-i)*6 +: 6];
        end
      end
    end
  endgenerate

  // One byte per frame; a new start restarts at the framing byte.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prog_busy <= 1'b0;
      prog_index <= 3'h0;
      prog_we <= 1'b0;
    end else if (prog_start_in) begin
      prog_busy <= 1'b1;
      prog_index <= 3'h0;
      prog_we <= prog_write_in;
    end else if (!go) begin
      prog_busy <= 1'b0;
      prog_index <= 3'h0;
    end else if (tx_load && prog_busy) begin
      prog_busy <= (prog_index != PROG_LAST);
      prog_index <= (prog_index == PROG_LAST) ? 3'h0 : prog_index + 3'h1;
    end
  end

  // Builds one control byte: framing, write enable, payload.
  function automatic logic [7:0] ctrl_byte(input logic busy, input logic [2:0] idx,
                                           input logic we, input logic [5:0] pay);
    logic [7:0] b;
    b = CTRL_IDLE;
    if (busy) begin
      b[CTRL_FRAME_POS] = (idx != 3'h0);
      b[CTRL_WE_B_POS] = ~we;
      b[5:0] = pay;
    end
    return b;
  endfunction : ctrl_byte

  // ==========================================================
  // Transmit framer.
  logic [FRAME_BITS-1:0] tx_shift;
  logic [5:0] tx_count;
  logic [7:0] sig_tx;

  // Only the hook bit carries meaning outward.
  always_comb begin
    sig_tx = SIG_IDLE;
    sig_tx[HOOK_POS] = ~hook_off_in;
  end

  // Frame loads at strobe rise and shifts on falling link edges.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_shift <= '0;
      tx_count <= FRAME_BITS_W;
    end else if (tx_load) begin
      tx_shift <= {tx_voice_in, DATA_IDLE,
                   ctrl_byte(prog_busy, prog_index, prog_we, prog_mem[prog_index]),
                   sig_tx};
      tx_count <= 6'h00;
    end else if (lclk_fall && sync2[SY_DIR] && tx_count != FRAME_BITS_W) begin
      tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
      tx_count <= tx_count + 6'h01;
    end
  end

  // Wire drive: one-wire mode drives only while the strobe is high.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_data_out <= 1'b0;
      tx_data_oe_out <= 1'b0;
    end else begin
      tx_data_out <= tx_shift[FRAME_BITS-1] & sync2[SY_DIR];
      tx_data_oe_out <= go & (sync2[SY_DIR] | ~one_wire);
    end
  end

  // ==========================================================
  // Receive deframer.
  logic [FRAME_BITS-1:0] rx_shift;
  logic [5:0] rx_count;
  logic rx_done;
  logic id_pending;
  logic rx_bit;
  logic [FRAME_BITS-1:0] rx_word;

  // Board data comes on the shared wire in one-wire mode; the code on rx.
  assign rx_bit = (one_wire && !id_pending) ? sync2[SY_TXI] : sync2[SY_RX];
  assign rx_done = lclk_fall && !sync2[SY_DIR] && rx_count == FRAME_BITS_W - 6'h01;
  // Whole frame as it stands once the last bit is on the wire.
  assign rx_word = {rx_shift[FRAME_BITS-2:0], rx_bit};

  // Receive frame starts when the strobe falls.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_shift <= '0;
      rx_count <= FRAME_BITS_W;
    end else if (dir_fall) begin
      rx_count <= 6'h00;
    end else if (lclk_fall && !sync2[SY_DIR] && rx_count != FRAME_BITS_W) begin
      rx_shift <= {rx_shift[FRAME_BITS-2:0], rx_bit};
      rx_count <= rx_count + 6'h01;
    end
  end

  // First frame after the run line rises holds the identification.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      id_pending <= 1'b1;
      id_code_out <= 8'h00;
      id_valid_out <= 1'b0;
    end else if (!go) begin
      id_pending <= 1'b1;
      id_valid_out <= 1'b0;
    end else if (rx_done && id_pending) begin
      id_pending <= 1'b0;
      id_code_out <= rx_word[VOICE_LSB +: 8];
      id_valid_out <= 1'b1;
    end
  end

  // Voice and line status from each ordinary received frame.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      voice_out <= 8'h00;
      voice_valid_out <= 1'b0;
      ring_detect_out <= 1'b0;
      line_current_out <= 1'b0;
    end else begin
      voice_valid_out <= rx_done & ~id_pending & go;
      if (rx_done && !id_pending && go) begin
        voice_out <= rx_word[VOICE_LSB +: 8];
        ring_detect_out <= rx_word[SIG_LSB + RING_POS];
        line_current_out <= rx_word[SIG_LSB + CURRENT_POS];
      end
    end
  end

  // ==========================================================
  // Status outputs.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      interface_reset_line_out <= 1'b0;
      prog_busy_out <= 1'b0;
      voice_taken_out <= 1'b0;
      one_wire_out <= 1'b0;
    end else begin
      interface_reset_line_out <= go;
      prog_busy_out <= prog_busy;
      voice_taken_out <= tx_load;
      one_wire_out <= one_wire;
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  chk_run_line_follow: assert property (!run_enable_in |=> ##1 !interface_reset_line_out)
    else $error("interface reset line released while run is low");
  chk_frame_bit_first: assert property (tx_load && prog_busy && prog_index == 3'h0
    |=> !tx_shift[CTRL_LSB + CTRL_FRAME_POS])
    else $error("first control byte framing bit not zero");
  chk_frame_bit_rest: assert property (tx_load && prog_busy && prog_index != 3'h0
    |=> tx_shift[CTRL_LSB + CTRL_FRAME_POS])
    else $error("later control byte framing bit not one");
  chk_write_enable_bit: assert property (tx_load && prog_busy
    |=> tx_shift[CTRL_LSB + CTRL_WE_B_POS] == !prog_we)
    else $error("write enable bit wrong");
  chk_hook_bit_value: assert property (tx_load
    |=> tx_shift[SIG_LSB + HOOK_POS] == !$past(hook_off_in))
    else $error("hook bit does not follow hook request");
  chk_data_slot_idle: assert property (tx_load
    |=> tx_shift[DATA_LSB +: 8] == DATA_IDLE && tx_shift[SIG_LSB + 7:SIG_LSB + 1] == 7'h00)
    else $error("unused slot bits not idle");
  chk_oe_one_wire: assert property (one_wire && !sync2[SY_DIR] |=> !tx_data_oe_out)
    else $error("one-wire transmit driven while strobe low");
  chk_tx_quiet_rx: assert property (!sync2[SY_DIR] |=> !tx_data_out)
    else $error("transmit data not idle outside strobe");

  // Counts control bytes sent since the last start, for the length check.
  logic [2:0] prog_loads;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prog_loads <= 3'h0;
    end else if (prog_start_in) begin
      prog_loads <= 3'h0;
    end else if (tx_load && prog_busy) begin
      prog_loads <= prog_loads + 3'h1;
    end
  end

  chk_prog_six_frames: assert property ($fell(prog_busy) && $past(go)
    |-> prog_loads == 3'(PROG_BYTES))
    else $error("programming sequence length wrong");
endmodule : subscriber_line_link_slave
`default_nettype wire

// ==== verif/line_board_model.sv ====
// Purpose: Behavioural line interface board, the link timing master.
// Assumes: Link clock of 200 ns, stepped on the 25 ns block clock.
// Notes: Released data wires show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module line_board_model (
  // Block clock used only for stepping.
  input wire logic clock_in,
  input wire logic tx_wire_in,
  // Link pins driven by the board.
  output logic link_clock_out,
  output logic strobe_out,
  output logic rx_data_out,
  output logic board_d_out,
  output logic board_oe_out,
  // Last frame captured from the module.
  output logic [31:0] got_out,
  output logic got_tgl_out
);
  // ==========================================================
  // Link frames
  // Idle levels; the link clock stands low outside frames.
  initial begin
    link_clock_out = 1'b0;
    strobe_out = 1'b0;
    rx_data_out = 1'b0;
    board_d_out = 1'b0;
    board_oe_out = 1'b0;
    got_out = '0;
    got_tgl_out = 1'b0;
  end
  // Half a link period is four block clocks.
  task automatic half();
    repeat (4) @(posedge clock_in);
  endtask : half
  // Module sends 32 bits with the strobe high; each is taken on a fall.
  task automatic take_frame();
    strobe_out <= 1'b1;
    repeat (16) @(posedge clock_in);
    for (int i = 31; i >= 0; i--) begin
      link_clock_out <= 1'b1;
      half();
      link_clock_out <= 1'b0;
      got_out[i] <= tx_wire_in;
      half();
    end
    got_tgl_out <= ~got_tgl_out;
  endtask : take_frame
  // Board sends 32 bits with the strobe low; the id byte leads on rx.
  task automatic give_frame(input logic [31:0] w, input logic one);
    strobe_out <= 1'b0;
    repeat (8) @(posedge clock_in);
    board_oe_out <= one;
    for (int i = 31; i >= 0; i--) begin
      link_clock_out <= 1'b1;
      rx_data_out <= (one && i < 24) ? ~w[i] : w[i];
      board_d_out <= w[i];
      half();
      link_clock_out <= 1'b0;
      half();
    end
    board_oe_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
    board_d_out <= ~board_d_out;
  endtask : give_frame
endmodule : line_board_model
`default_nettype wire

// ==== verif/subscriber_line_link_slave_test.sv ====
// Purpose: Self-checking bench for the subscriber line link slave.
// Assumes: Board model is link master; block clock 40 MHz.
// Notes: Drivers queue expected words; monitors pop them as results appear.
`timescale 1ns/1ps
`default_nettype none
module subscriber_line_link_slave_test;
  import subscriber_line_link_pkg::*;
  // ==========================================================
  // Stimulus and wiring
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic run_enable_in = 1'b0;
  logic hook_off_in = 1'b0;
  logic [7:0] tx_voice_in = 8'h00;
  logic prog_start_in = 1'b0;
  logic prog_write_in = 1'b0;
  logic [35:0] prog_bits_in = 36'h0;
  logic one_wire_b_in = 1'b1;
  logic tx_data_out, tx_data_oe_out, interface_reset_line_out, prog_busy_out;
  logic voice_taken_out, voice_valid_out, ring_detect_out, line_current_out;
  logic id_valid_out, one_wire_out;
  logic [7:0] voice_out, id_code_out;
  wire logic link_clock, strobe, rx_data, b_d, b_oe, got_tgl, tx_wire;
  wire logic [31:0] got;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'h14E05781;
  int idx = -1;
  int n_taken = 0;
  logic [31:0] sigw = 32'h00000000;
  logic pwr;
  logic [35:0] pbits;
  logic [31:0] lastw;
  logic [31:0] txq[$];
  logic [7:0] rxq[$];
  // The shared transmit wire carries whichever party enables it.
  assign tx_wire = tx_data_oe_out ? tx_data_out : b_d;
  always #12.5 clock_in = ~clock_in;
  subscriber_line_link_slave dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .link_clock_in(link_clock), .link_direction_strobe_in(strobe),
    .rx_data_in(rx_data), .one_wire_b_in(one_wire_b_in), .tx_data_in(tx_wire),
    .tx_data_out(tx_data_out), .tx_data_oe_out(tx_data_oe_out),
    .interface_reset_line_out(interface_reset_line_out),
    .run_enable_in(run_enable_in), .hook_off_in(hook_off_in),
    .tx_voice_in(tx_voice_in), .prog_start_in(prog_start_in),
    .prog_write_in(prog_write_in), .prog_bits_in(prog_bits_in),
    .prog_busy_out(prog_busy_out), .voice_taken_out(voice_taken_out),
    .voice_out(voice_out), .voice_valid_out(voice_valid_out),
    .ring_detect_out(ring_detect_out), .line_current_out(line_current_out),
    .id_code_out(id_code_out), .id_valid_out(id_valid_out),
    .one_wire_out(one_wire_out));
  line_board_model brd (.clock_in(clock_in), .tx_wire_in(tx_wire),
    .link_clock_out(link_clock), .strobe_out(strobe), .rx_data_out(rx_data),
    .board_d_out(b_d), .board_oe_out(b_oe), .got_out(got), .got_tgl_out(got_tgl));
  // ==========================================================
  // Checking
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Each captured module frame is compared with the oldest note.
  always @(got_tgl) begin
    if (txq.size() > 0) chk("tx frame", txq.pop_front(), got);
  end
  // Received voice and wire ownership are watched every clock.
  always @(posedge clock_in) begin
    if (voice_valid_out === 1'b1) chk("voice", rxq.size() ? rxq.pop_front() : 8'hXX, voice_out);
    if (tx_data_oe_out === 1'b1 && b_oe === 1'b1) chk("wire fight", 0, 1);
    if (voice_taken_out === 1'b1) n_taken++;
  end
  // Starts or restarts a programming sequence with random payloads.
  task automatic start_prog();
    logic [31:0] r;
    r = $random(seed);
    pwr = r[31];
    pbits = {r[3:0], $random(seed)};
    prog_bits_in <= pbits;
    prog_write_in <= pwr;
    prog_start_in <= 1'b1;
    @(posedge clock_in);
    prog_start_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk("busy", 1, prog_busy_out);
    idx = 0;
  endtask : start_prog
  // One module frame then one board frame, with random contents.
  task automatic frame(input logic one, input logic first);
    logic [31:0] v;
    logic [7:0] c;
    v = $random(seed);
    hook_off_in <= v[8];
    tx_voice_in <= v[7:0];
    c = (idx < 0) ? CTRL_IDLE : {idx != 0, ~pwr, pbits[35 - 6 * idx -: 6]};
    txq.push_back({v[7:0], DATA_IDLE, c, SIG_IDLE[7:1], ~v[8]});
    idx = (idx < 0 || idx == 5) ? -1 : idx + 1;
    brd.take_frame();
    lastw = $random(seed);
    // The identification frame gives no voice and leaves line status as it was.
    if (!first) begin
      rxq.push_back(lastw[31:24]);
      sigw = lastw;
    end
    brd.give_frame(lastw, one);
    for (int k = 0; k < 40 && rxq.size() > 0; k++) @(posedge clock_in);
    if (rxq.size() > 0) begin
      n_errors++;
      conclude();
    end
    @(posedge clock_in);
    chk("ring", sigw[RING_POS], ring_detect_out);
    chk("current", sigw[CURRENT_POS], line_current_out);
  endtask : frame
  // Reset, then both wire modes with programming, restart and idle frames.
  initial begin
    repeat (4) @(posedge clock_in);
    chk("reset line", 0, {interface_reset_line_out, tx_data_oe_out});
    rst_b_in <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      run_enable_in <= 1'b0;
      one_wire_b_in <= ~m[0];
      repeat (4) @(posedge clock_in);
      chk("reset line", 0, interface_reset_line_out);
      run_enable_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      chk("run line", 1, interface_reset_line_out);
      chk("mode", m[0], one_wire_out);
      idx = -1;
      for (int f = 0; f < 12; f++) begin
        if (f == 1 || f == 4) start_prog();
        if (f == 10) chk("busy", 0, prog_busy_out);
        frame(m[0], f == 0);
        if (f == 0) chk("id", {1'b1, lastw[31:24]}, {id_valid_out, id_code_out});
      end
    end
    chk("tx left", 0, txq.size());
    chk("voice taken", 24, n_taken);
    conclude();
  end
endmodule : subscriber_line_link_slave_test
`default_nettype wire
